// ==== ssrdm_pkg.sv ====
`default_nettype none
package ssrdm_pkg;
  // Clock and derived cycle counts.
  localparam int CLK_PERIOD_NS = 10;
  localparam int IDLE_ENTRY_NS = 6;
  localparam int IDLE_ENTRY_CYC = (IDLE_ENTRY_NS / CLK_PERIOD_NS < 1) ? 1 :
    IDLE_ENTRY_NS / CLK_PERIOD_NS;
  localparam int U23_EXIT_US = 1;
  localparam int U23_EXIT_CYC = (U23_EXIT_US * 1000 + CLK_PERIOD_NS - 1) /
    CLK_PERIOD_NS;
  localparam int DISC_EXIT_US = 2;
  localparam int DISC_EXIT_CYC = (DISC_EXIT_US * 1000 + CLK_PERIOD_NS - 1) /
    CLK_PERIOD_NS;
  localparam int U23_IDLE_US = 10;
  localparam int U23_IDLE_CYC = (U23_IDLE_US * 1000 + CLK_PERIOD_NS - 1) /
    CLK_PERIOD_NS;
  localparam int RXDET_PERIOD_US = 100;
  localparam int RXDET_PERIOD_CYC = RXDET_PERIOD_US * 1000 / CLK_PERIOD_NS;

  // Three-level pin codes from the pin sense comparators.
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_FLOAT = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;

  // Positions inside the vector of synchronised pin inputs.
  localparam int ASYNC_W = 13;
  localparam int PIN_SEL = 0;
  localparam int PIN_FE_HOST = 1;
  localparam int PIN_FE_CONN = 2;
  localparam int PIN_TRAFFIC = 3;
  localparam int PIN_LFPS = 4;
  localparam int PIN_HA = 5;
  localparam int PIN_HB = 7;
  localparam int PIN_CA = 9;
  localparam int PIN_CB = 11;

  // Register map and fields.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CONFIG = 8'h08;
  localparam logic [7:0] REG_LOG = 8'h0c;
  localparam int CTRL_LOG_EN = 0;
  localparam int CTRL_FORCE_DISC = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int LOG_W = 8;
  localparam int LOG_DEPTH = 8;

  typedef enum logic [3:0] {
    ST_DISC = 4'h1,
    ST_EXIT = 4'h2,
    ST_U0 = 4'h4,
    ST_U23 = 4'h8
  } ssrdm_state_t;

  // Entry {de[1:0], swing, eq[1:0]}; de 0/3.5/6 dB, swing 0.9/1.1 V,
  // eq 0/3/6/9 dB. Index is pin_a * 3 + pin_b.
  localparam logic [4:0] HOST_TBL [0:8] = '{5'h0d, 5'h09, 5'h05, 5'h01,
    5'h0c, 5'h08, 5'h04, 5'h00, 5'h16};
  localparam logic [4:0] CONN_TBL [0:8] = '{5'h14, 5'h0c, 5'h08, 5'h10,
    5'h0e, 5'h0a, 5'h16, 5'h12, 5'h17};
endpackage : ssrdm_pkg
`default_nettype wire

// ==== ssrdm_top.sv ====
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module ssrdm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [0:DEPTH-1];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  // Full and empty come from the count so neither can lie.
  assign in_ready = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage needs no reset; only valid entries are ever read.
  always_ff @(posedge aclk)
  begin
    if (push)
      mem_ff[wr_ptr_ff] <= in_data;
  end
endmodule : ssrdm_fifo

module ssrdm_top
  import ssrdm_pkg::*;
#(
  parameter int RXDET_CYC = RXDET_PERIOD_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic orient_sel,
  input wire logic [1:0] host_side_cond_pin_a,
  input wire logic [1:0] host_side_cond_pin_b,
  input wire logic [1:0] conn_side_cond_pin_a,
  input wire logic [1:0] conn_side_cond_pin_b,
  input wire logic fe_term_host,
  input wire logic fe_term_conn,
  input wire logic ss_traffic_det,
  input wire logic lfps_det,
  output logic conn1_route_en,
  output logic conn2_route_en,
  output logic conn1_gnd_en,
  output logic conn2_gnd_en,
  output logic [1:0] host_deemphasis_level,
  output logic host_output_swing_level,
  output logic [1:0] host_rx_equalization_gain,
  output logic [1:0] conn_deemphasis_level,
  output logic conn_output_swing_level,
  output logic [1:0] conn_rx_equalization_gain,
  output logic rx_term_en,
  output logic redrive_en,
  output logic tx_idle,
  output logic rxdet_start
);
  logic [ASYNC_W-1:0] pin_raw;
  logic [ASYNC_W-1:0] pin_val;

  // Every pin is asynchronous; a change counts once stages two and three
  // agree, which also filters a single-cycle glitch.
  assign pin_raw = {conn_side_cond_pin_b, conn_side_cond_pin_a,
    host_side_cond_pin_b, host_side_cond_pin_a, lfps_det, ss_traffic_det,
    fe_term_conn, fe_term_host, orient_sel};
  for (genvar i = 0; i < ASYNC_W; i++)
  begin : g_sync
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic val_ff;
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        s1_ff <= 1'b0;
        s2_ff <= 1'b0;
        s3_ff <= 1'b0;
        val_ff <= 1'b0;
      end
      else
      begin
        s1_ff <= pin_raw[i];
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        if (s2_ff == s3_ff)
          val_ff <= s3_ff;
      end
    end
    assign pin_val[i] = val_ff;
  end

  logic sel_val;
  logic both_term;
  logic act_val;
  logic lfps_val;
  logic [1:0] lv_ha;
  logic [1:0] lv_hb;
  logic [1:0] lv_ca;
  logic [1:0] lv_cb;
  logic [3:0] host_idx;
  logic [3:0] conn_idx;
  logic [4:0] host_set;
  logic [4:0] conn_set;

  // The unused fourth code is read as floating, the safe middle level.
  assign sel_val = pin_val[PIN_SEL];
  assign both_term = pin_val[PIN_FE_HOST] & pin_val[PIN_FE_CONN];
  assign lfps_val = pin_val[PIN_LFPS];
  assign act_val = pin_val[PIN_TRAFFIC] | lfps_val;
  assign lv_ha = (pin_val[PIN_HA+:2] == 2'h3) ? LVL_FLOAT : pin_val[PIN_HA+:2];
  assign lv_hb = (pin_val[PIN_HB+:2] == 2'h3) ? LVL_FLOAT : pin_val[PIN_HB+:2];
  assign lv_ca = (pin_val[PIN_CA+:2] == 2'h3) ? LVL_FLOAT : pin_val[PIN_CA+:2];
  assign lv_cb = (pin_val[PIN_CB+:2] == 2'h3) ? LVL_FLOAT : pin_val[PIN_CB+:2];
  // Widen before the product so the high row index is not truncated.
  assign host_idx = ({2'h0, lv_ha} * 4'h3) + {2'h0, lv_hb};
  assign conn_idx = ({2'h0, lv_ca} * 4'h3) + {2'h0, lv_cb};
  assign host_set = HOST_TBL[host_idx];
  assign conn_set = CONN_TBL[conn_idx];

  logic [1:0] ctrl_ff;
  logic log_en;
  logic force_disc;
  logic [15:0] tick_cnt_ff;
  logic tick;
  assign log_en = ctrl_ff[CTRL_LOG_EN];
  assign force_disc = ctrl_ff[CTRL_FORCE_DISC];
  assign tick = (tick_cnt_ff == 16'(RXDET_CYC - 1));

  // Divider for the periodic receiver-detect enable pulse.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick_cnt_ff <= '0;
    else
      tick_cnt_ff <= tick ? '0 : tick_cnt_ff + 16'h0001;
  end

  ssrdm_state_t st_ff;
  ssrdm_state_t st_want;
  logic [7:0] exit_cnt_ff;
  logic [9:0] idle_cnt_ff;
  logic log_ready;
  logic take;
  logic log_pop;
  logic [LOG_W-1:0] log_data;
  logic log_valid;

  // Next state; the event log may stall a move only while logging is on.
  always_comb
  begin
    st_want = st_ff;
    case (st_ff)
      ST_DISC:
        if (tick && both_term && !force_disc)
          st_want = ST_EXIT;
      ST_EXIT:
        if (exit_cnt_ff == 8'h00)
          st_want = ST_U0;
      ST_U0:
        if (!act_val && idle_cnt_ff == 10'(U23_IDLE_CYC - 1))
          st_want = ST_U23;
      ST_U23:
        if (tick && !both_term)
          st_want = ST_DISC;
        else if (act_val && both_term)
          st_want = ST_EXIT;
      default:
        st_want = ST_DISC;
    endcase
    if (force_disc)
      st_want = ST_DISC;
  end
  assign take = (st_want != st_ff) && (!log_en || log_ready);

  // State register and the exit and idle timers.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_ff <= ST_DISC;
      exit_cnt_ff <= '0;
      idle_cnt_ff <= '0;
    end
    else
    begin
      if (take)
        st_ff <= st_want;
      if (take && st_want == ST_EXIT)
        exit_cnt_ff <= (st_ff == ST_U23) ? 8'(U23_EXIT_CYC - 1) :
          8'(DISC_EXIT_CYC - 1);
      else if (exit_cnt_ff != 8'h00)
        exit_cnt_ff <= exit_cnt_ff - 8'h01;
      idle_cnt_ff <= (st_ff != ST_U0 || act_val) ? '0 :
        (idle_cnt_ff == 10'(U23_IDLE_CYC - 1)) ? idle_cnt_ff :
        idle_cnt_ff + 10'h001;
    end
  end

  // While logging is on, every transition is logged as {old state, new state}.
  ssrdm_fifo #(
    .WIDTH(LOG_W),
    .DEPTH(LOG_DEPTH)
  ) u_log (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_data({st_ff, st_want}),
    .in_valid(take && log_en),
    .in_ready(log_ready),
    .out_data(log_data),
    .out_valid(log_valid),
    .out_ready(log_pop)
  );

  // Pin side outputs, all registered; a one-cycle lag fits the idle
  // entry time only because that time is below one clock.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      conn1_route_en <= 1'b0;
      conn2_route_en <= 1'b0;
      conn1_gnd_en <= 1'b1;
      conn2_gnd_en <= 1'b1;
      host_deemphasis_level <= '0;
      host_output_swing_level <= 1'b0;
      host_rx_equalization_gain <= '0;
      conn_deemphasis_level <= '0;
      conn_output_swing_level <= 1'b0;
      conn_rx_equalization_gain <= '0;
      rx_term_en <= 1'b0;
      redrive_en <= 1'b0;
      tx_idle <= 1'b1;
      rxdet_start <= 1'b0;
    end
    else
    begin
      conn1_route_en <= sel_val;
      conn2_route_en <= !sel_val;
      conn1_gnd_en <= !sel_val;
      conn2_gnd_en <= sel_val;
      host_deemphasis_level <= lfps_val ? 2'h0 : host_set[4:3];
      host_output_swing_level <= host_set[2];
      host_rx_equalization_gain <= host_set[1:0];
      conn_deemphasis_level <= lfps_val ? 2'h0 : conn_set[4:3];
      conn_output_swing_level <= conn_set[2];
      conn_rx_equalization_gain <= conn_set[1:0];
      rx_term_en <= (st_ff != ST_DISC);
      redrive_en <= (st_ff == ST_U0);
      tx_idle <= !(st_ff == ST_U0 && act_val);
      rxdet_start <= tick && (st_ff == ST_DISC || st_ff == ST_U23);
    end
  end

  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic w_strb0_ff;
  logic wr_go;
  logic [31:0] rd_word;
  logic rd_ok;
  logic ar_take;

  // Read decode; a read of the log pops one entry if there is one.
  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign log_pop = ar_take && (s_axi_araddr == REG_LOG) && log_valid;
  assign rd_ok = (s_axi_araddr == REG_CTRL) || (s_axi_araddr == REG_STATUS) ||
    (s_axi_araddr == REG_CONFIG) || (s_axi_araddr == REG_LOG);
  assign rd_word = (s_axi_araddr == REG_CTRL) ? {30'h0, ctrl_ff} :
    (s_axi_araddr == REG_STATUS) ? {21'h0, lfps_val, pin_val[PIN_TRAFFIC],
      pin_val[PIN_FE_CONN], pin_val[PIN_FE_HOST], sel_val, log_ready,
      log_valid, st_ff} :
    (s_axi_araddr == REG_CONFIG) ? {22'h0, conn_set, host_set} :
    (s_axi_araddr == REG_LOG) ? {23'h0, log_valid, log_data} : 32'h0;

  // Write channel: address and data are caught in either order.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_addr_ff <= '0;
      w_data_ff <= '0;
      w_strb0_ff <= 1'b0;
      ctrl_ff <= CTRL_RESET;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_ff <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_ff <= s_axi_wdata;
        w_strb0_ff <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_ff == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
        if (aw_addr_ff == REG_CTRL && w_strb0_ff)
          ctrl_ff <= w_data_ff[1:0];
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read channel: one read at a time, answered the cycle after arvalid.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Checks; the state register is the one-hot reference throughout.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_sel_high;
    sel_val |=> conn1_route_en && !conn2_route_en;
  endproperty
  a_sel_high: assert property (p_sel_high)
    else $error("port 1 not routed while select high");

  // The first edge after reset still shows reset values, so checks that
  // look one cycle back skip the edges where reset was still sampled.
  property p_sel_low;
    $past(aresetn) && !sel_val |=>
      conn2_route_en && conn1_gnd_en && !conn2_gnd_en;
  endproperty
  a_sel_low: assert property (p_sel_low)
    else $error("port 2 not routed while select low");

  property p_park;
    conn1_route_en != conn1_gnd_en && conn2_route_en != conn2_gnd_en;
  endproperty
  a_park: assert property (p_park)
    else $error("unselected port not parked");

  property p_host_set;
    $past(aresetn) && !lfps_val |=>
      host_output_swing_level == $past(host_set[2]) &&
      host_deemphasis_level == $past(host_set[4:3]);
  endproperty
  a_host_set: assert property (p_host_set)
    else $error("host settings do not follow the pins");

  property p_lfps_de;
    lfps_val |=> host_deemphasis_level == 2'h0 &&
      conn_deemphasis_level == 2'h0;
  endproperty
  a_lfps_de: assert property (p_lfps_de)
    else $error("de-emphasis not off during LFPS");

  property p_disc_leave;
    st_ff == ST_DISC && !both_term |=> st_ff != ST_EXIT;
  endproperty
  a_disc_leave: assert property (p_disc_leave)
    else $error("left disconnect without both terminations");

  // Age in the exit state, saturating, and whether it was entered from
  // U2/U3; a counter keeps the long wait out of the property itself.
  logic [7:0] exit_age_ff;
  logic from_u23_ff;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      exit_age_ff <= '0;
      from_u23_ff <= 1'b0;
    end
    else
    begin
      exit_age_ff <= (st_ff != ST_EXIT) ? 8'h00 :
        (exit_age_ff == 8'hff) ? exit_age_ff : exit_age_ff + 8'h01;
      from_u23_ff <= (st_ff == ST_U23) ? 1'b1 :
        (st_ff == ST_EXIT) ? from_u23_ff : 1'b0;
    end
  end

  property p_u23_exit;
    st_ff == ST_EXIT && from_u23_ff &&
      exit_age_ff < 8'(U23_EXIT_CYC - 1) |=> st_ff != ST_U0;
  endproperty
  a_u23_exit: assert property (p_u23_exit)
    else $error("U2/U3 exit ended early");

  property p_u23_exit_time;
    st_ff == ST_EXIT && from_u23_ff &&
      exit_age_ff == 8'(U23_EXIT_CYC - 1) && !force_disc &&
      (!log_en || log_ready) |=> st_ff == ST_U0;
  endproperty
  a_u23_exit_time: assert property (p_u23_exit_time)
    else $error("U2/U3 exit did not end on time");

  property p_idle_out;
    st_ff == ST_U0 && !act_val |=> tx_idle && redrive_en;
  endproperty
  a_idle_out: assert property (p_idle_out)
    else $error("output not idle one cycle after input idle");

  property p_detect;
    tick && (st_ff == ST_DISC || st_ff == ST_U23) |=> rxdet_start;
  endproperty
  a_detect: assert property (p_detect)
    else $error("periodic receiver detect missing");

  property p_term;
    st_ff == ST_U0 |-> rx_term_en ##1 (rx_term_en || st_ff == ST_DISC);
  endproperty
  a_term: assert property (p_term)
    else $error("termination off while active");

  c_u0: cover property (st_ff == ST_EXIT ##1 st_ff == ST_U0);
  c_u23: cover property (st_ff == ST_U0 ##1 st_ff == ST_U23);
  c_lost: cover property (st_ff == ST_U23 ##1 st_ff == ST_DISC);
  c_log_full: cover property (log_en && !log_ready);
endmodule : ssrdm_top

`default_nettype wire

// ==== ssrdm_link_partner.sv ====
`timescale 1ns/1ps
`default_nettype none

module ssrdm_link_partner #(
  parameter int LAG = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic attach_host,
  input wire logic attach_conn,
  input wire logic send_traffic,
  input wire logic send_lfps,
  output logic fe_term_host,
  output logic fe_term_conn,
  output logic ss_traffic_det,
  output logic lfps_det
);
  logic [3:0] pipe_ff [LAG];

  // Commands pass a short pipe; a larger LAG models a slow far end.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < LAG; i++)
        pipe_ff[i] <= 4'h0;
    end
    else
    begin
      pipe_ff[0] <= {attach_host, attach_conn, send_traffic, send_lfps};
      for (int i = 1; i < LAG; i++)
        pipe_ff[i] <= pipe_ff[i-1];
    end
  end

  // An unplugged receiver shows no termination; nothing is sent only when both are unplugged.
  assign fe_term_host = pipe_ff[LAG-1][3];
  assign fe_term_conn = pipe_ff[LAG-1][2];
  assign ss_traffic_det = pipe_ff[LAG-1][1] & (fe_term_host | fe_term_conn);
  assign lfps_det = pipe_ff[LAG-1][0] & (fe_term_host | fe_term_conn);
endmodule : ssrdm_link_partner
`default_nettype wire

// ==== ssrdm_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module ssrdm_top_tb
  import ssrdm_pkg::*;
;
  localparam int RXDET = 16;
  localparam int LIMIT = 30000;
  // Expected {host, conn} settings {de, swing, eq}; row index is a*3+b.
  localparam logic [9:0] ROWS [9] = '{10'h1b4, 10'h12c, 10'h0a8, 10'h030,
    10'h18e, 10'h10a, 10'h096, 10'h012, 10'h2d7};
  // Expected log words {valid, old state, new state} in order.
  localparam logic [8:0] LOGS [9] = '{9'h112, 9'h124, 9'h148, 9'h182,
    9'h124, 9'h148, 9'h182, 9'h124, 9'h148};
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic orient_sel = 1'b0;
  logic [1:0] host_side_cond_pin_a = 2'h0, host_side_cond_pin_b = 2'h0;
  logic [1:0] conn_side_cond_pin_a = 2'h0, conn_side_cond_pin_b = 2'h0;
  logic attach_host = 1'b0, attach_conn = 1'b0;
  logic send_traffic = 1'b0, send_lfps = 1'b0;
  logic fe_term_host, fe_term_conn, ss_traffic_det, lfps_det;
  logic conn1_route_en, conn2_route_en, conn1_gnd_en, conn2_gnd_en;
  logic [1:0] host_deemphasis_level, host_rx_equalization_gain;
  logic [1:0] conn_deemphasis_level, conn_rx_equalization_gain;
  logic host_output_swing_level, conn_output_swing_level;
  logic rx_term_en, redrive_en, tx_idle, rxdet_start;
  int failures = 0, tests_run = 0, cycles = 0, pulses = 0, p0;
  logic [31:0] d;
  logic [1:0] r;

  ssrdm_top #(.RXDET_CYC(RXDET)) u_dut (.*);
  ssrdm_link_partner #(.LAG(2)) u_partner (.*);

  always #5 aclk = ~aclk;

  // Cycle watchdog and detection pulse counter.
  always @(posedge aclk)
  begin
    cycles++;
    if (rxdet_start === 1'b1)
      pulses++;
    if (cycles == LIMIT)
    begin
      failures++;
      finish_test();
    end
  end

  task finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask : chk_bit

  // Both channels are offered together and each is released when taken.
  task axi_write(input logic [7:0] a, input logic [31:0] v);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_write

  task axi_read(input logic [7:0] a);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_read

  // Polls the state field up to 1001 times; only a machine slower than that fails the check.
  task wait_state(input logic [3:0] st);
    axi_read(REG_STATUS);
    for (int i = 0; i < 1000 && d[3:0] !== st; i++)
      axi_read(REG_STATUS);
    chk_word({28'h0, d[3:0]}, {28'h0, st});
  endtask : wait_state

  // Main sequence; pins settle through the sync filter before checks.
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_bit(rx_term_en, 1'b0);
    chk_bit(redrive_en, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 9; i++)
    begin
      @(posedge aclk);
      orient_sel <= (i % 2 == 1);
      host_side_cond_pin_a <= 2'(i / 3);
      host_side_cond_pin_b <= 2'(i % 3);
      conn_side_cond_pin_a <= 2'(i / 3);
      conn_side_cond_pin_b <= 2'(i % 3);
      repeat (8) @(posedge aclk);
      chk_word({27'h0, host_deemphasis_level, host_output_swing_level,
        host_rx_equalization_gain}, {27'h0, ROWS[i][9:5]});
      chk_word({27'h0, conn_deemphasis_level, conn_output_swing_level,
        conn_rx_equalization_gain}, {27'h0, ROWS[i][4:0]});
      chk_bit(conn1_route_en, orient_sel);
      chk_bit(conn2_route_en, !orient_sel);
      chk_bit(conn1_gnd_en, !orient_sel);
      chk_bit(conn2_gnd_en, orient_sel);
    end
    $display("test settings done");
    p0 = pulses;
    repeat (4 * RXDET) @(posedge aclk);
    chk_bit(pulses - p0 >= 3, 1'b1);
    axi_write(REG_CTRL, 32'h1);
    chk_word({30'h0, r}, {30'h0, RESP_OKAY});
    axi_write(8'h10, 32'h2);
    chk_word({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_read(8'h20);
    chk_word({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_read(REG_CTRL);
    chk_word(d, 32'h1);
    axi_read(REG_CONFIG);
    chk_word(d, {22'h0, ROWS[8][4:0], ROWS[8][9:5]});
    $display("test registers done");
    attach_host <= 1'b1;
    repeat (4 * RXDET) @(posedge aclk);
    wait_state(4'h1);
    attach_conn <= 1'b1;
    wait_state(4'h4);
    chk_bit(rx_term_en, 1'b1);
    chk_bit(redrive_en, 1'b1);
    send_traffic <= 1'b1;
    repeat (1200) @(posedge aclk);
    chk_bit(tx_idle, 1'b0);
    wait_state(4'h4);
    send_traffic <= 1'b0;
    repeat (9) @(posedge aclk);
    chk_bit(tx_idle, 1'b1);
    wait_state(4'h8);
    p0 = pulses;
    repeat (4 * RXDET) @(posedge aclk);
    chk_bit(pulses - p0 >= 3, 1'b1);
    send_lfps <= 1'b1;
    repeat (9) @(posedge aclk);
    chk_word({30'h0, host_deemphasis_level}, 32'h0);
    chk_word({30'h0, conn_deemphasis_level}, 32'h0);
    send_lfps <= 1'b0;
    repeat (9) @(posedge aclk);
    chk_word({30'h0, host_deemphasis_level}, 32'h2);
    wait_state(4'h4);
    wait_state(4'h8);
    send_traffic <= 1'b1;
    repeat (10) @(posedge aclk);
    send_traffic <= 1'b0;
    wait_state(4'h4);
    $display("test power states done");
    // The log is full now, so the idle transition must wait for a pop.
    repeat (1300) @(posedge aclk);
    axi_read(REG_STATUS);
    chk_word({26'h0, d[5:0]}, 32'h14);
    for (int i = 0; i < 9; i++)
    begin
      axi_read(REG_LOG);
      chk_word(d, {23'h0, LOGS[i]});
    end
    axi_read(REG_LOG);
    chk_bit(d[8], 1'b0);
    $display("test log buffer done");
    // Forced disconnect overrides attached receivers and is logged.
    axi_write(REG_CTRL, 32'h3);
    wait_state(4'h1);
    axi_read(REG_LOG);
    chk_word(d, {23'h0, 9'h181});
    axi_write(REG_CTRL, 32'h1);
    wait_state(4'h8);
    $display("test forced disconnect done");
    attach_host <= 1'b0;
    attach_conn <= 1'b0;
    wait_state(4'h1);
    chk_bit(rx_term_en, 1'b0);
    $display("test disconnect done");
    finish_test();
  end
endmodule : ssrdm_top_tb
`default_nettype wire
